// File: design/rstd_pkg.sv
// package: register map, field layout and bus types of the reference/test block
package rstd_pkg;

  // ********************
  // register map
  // ********************
  localparam logic [31:0] RSTD_REF_INDEX = 32'h0000_000f;
  localparam logic [31:0] RSTD_POS_INDEX = 32'h0000_0010;
  localparam logic [31:0] RSTD_NEG_INDEX = 32'h0000_0011;
  localparam int RSTD_NREGS = 3;
  localparam int RSTD_IDX_W = 2;
  localparam logic [7:0] RSTD_REF_RESET = 8'h00;
  localparam logic [7:0] RSTD_POS_RESET = 8'h00;
  localparam logic [7:0] RSTD_NEG_RESET = 8'h00;

  // ********************
  // field layout
  // ********************
  localparam int RSTD_PSEL_LSB = 3;
  localparam int RSTD_PSEL_MSB = 5;
  localparam int RSTD_NSEL_LSB = 0;
  localparam int RSTD_NSEL_MSB = 2;
  localparam int RSTD_CONN_BIT = 7;
  localparam int RSTD_MAG_LSB = 0;
  localparam int RSTD_MAG_MSB = 4;
  localparam logic [7:0] RSTD_REF_WMASK = 8'h3f;
  localparam logic [7:0] RSTD_TST_WMASK = 8'h9f;

  // reference select codes
  localparam logic [2:0] RSTD_SEL_INTERNAL = 3'h0;
  localparam logic [2:0] RSTD_SEL_SUPPLY = 3'h4;

  // ********************
  // ahb-lite
  // ********************
  localparam logic [1:0] RSTD_HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] RSTD_HSIZE_WORD = 3'h2;

  typedef struct packed {
    logic [2:0] pos_reference_select;
    logic [2:0] neg_reference_select;
  } rstd_ref_t;

  typedef struct packed {
    logic pin_connect;
    logic [4:0] magnitude;
  } rstd_test_t;

endpackage : rstd_pkg

// File: design/rstd_regfile.sv
// small register store: three byte registers with write masks, registered read
`timescale 1ns/1ps
module rstd_regfile (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic wr_en,
  input wire logic [rstd_pkg::RSTD_IDX_W-1:0] wr_idx,
  input wire logic [7:0] wr_data,
  input wire logic rd_en,
  input wire logic [rstd_pkg::RSTD_IDX_W-1:0] rd_idx,
  output logic [7:0] rd_data,
  output logic [7:0] reg_ref,
  output logic [7:0] reg_pos,
  output logic [7:0] reg_neg
);
  import rstd_pkg::*;

  logic [7:0] mem_q [RSTD_NREGS];

  function automatic logic [7:0] wmask(input logic [RSTD_IDX_W-1:0] i);
    wmask = (i == '0) ? RSTD_REF_WMASK : RSTD_TST_WMASK;
  endfunction : wmask

  // reserved bits never store, so they read back as zero
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mem_q[0] <= RSTD_REF_RESET; // R01
      mem_q[1] <= RSTD_POS_RESET; // R05
      mem_q[2] <= RSTD_NEG_RESET; // R09
    end else if (wr_en && int'(wr_idx) < RSTD_NREGS) begin
      mem_q[wr_idx] <= wr_data & wmask(wr_idx); // R10
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data <= 8'h00;
    end else if (rd_en && wr_en && wr_idx == rd_idx) begin
      // a pipelined read of the register being written sees the new byte
      rd_data <= wr_data & wmask(wr_idx); // R10
    end else if (rd_en) begin
      rd_data <= (int'(rd_idx) < RSTD_NREGS) ? mem_q[rd_idx] : 8'h00;
    end
  end

  assign reg_ref = mem_q[0];
  assign reg_pos = mem_q[1];
  assign reg_neg = mem_q[2];

endmodule : rstd_regfile

// File: design/rstd_top.sv
// reference source select and test level registers behind an ahb-lite slave
// Contract
// R01: reference register at 0x0f, resets zero
// R02: bits 5:3 choose positive reference
// R03: bits 2:0 choose negative reference
// R04: software avoids reserved select codes 101-111
// R05: positive test register at 0x10, resets zero
// R06: bit 7 connects positive generator to pin
// R07: bits 4:0 set positive generator magnitude
// R08: software writes only defined magnitude codes
// R09: negative test register at 0x11, resets zero
// R10: reserved bits written zero, read zero
`timescale 1ns/1ps
module rstd_top (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output rstd_pkg::rstd_ref_t ref_select,
  output rstd_pkg::rstd_test_t pos_test,
  output rstd_pkg::rstd_test_t neg_test
);
  import rstd_pkg::*;

  // ********************
  // address phase capture
  // ********************
  typedef enum logic [2:0] {
    RSTD_IDLE = 3'b001,
    RSTD_WR = 3'b010,
    RSTD_RD = 3'b100
  } rstd_phase_t;

  rstd_phase_t phase_q;
  logic [RSTD_IDX_W-1:0] idx_q;
  logic hit_q;
  logic take;
  logic hit;
  logic [RSTD_IDX_W-1:0] idx;
  logic [7:0] rd_byte;
  logic [7:0] reg_ref;
  logic [7:0] reg_pos;
  logic [7:0] reg_neg;

  // byte address is the printed offset times four; only word sized
  function automatic logic map_hit(input logic [31:0] a, input logic [2:0] s);
    map_hit = (s == RSTD_HSIZE_WORD) && (a[1:0] == 2'h0) &&
              ((a[31:2] == RSTD_REF_INDEX[29:0]) ||
               (a[31:2] == RSTD_POS_INDEX[29:0]) ||
               (a[31:2] == RSTD_NEG_INDEX[29:0]));
  endfunction : map_hit

  function automatic logic [RSTD_IDX_W-1:0] map_idx(input logic [31:0] a);
    logic [31:0] d;
    d = {2'h0, a[31:2]} - RSTD_REF_INDEX;
    map_idx = d[RSTD_IDX_W-1:0];
  endfunction : map_idx

  assign take = hsel && hready && (htrans == RSTD_HTRANS_NONSEQ);
  assign hit = map_hit(haddr, hsize);
  assign idx = map_idx(haddr);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      phase_q <= RSTD_IDLE;
    end else if (hready) begin
      if (take) begin
        phase_q <= hwrite ? RSTD_WR : RSTD_RD;
      end else begin
        phase_q <= RSTD_IDLE;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      idx_q <= '0;
      hit_q <= 1'b0;
    end else if (take) begin
      idx_q <= idx;
      hit_q <= hit;
    end
  end

  // ********************
  // register store
  // ********************
  // unmapped writes are dropped; unmapped reads return zero, always okay
  rstd_regfile u_regs (
    .mclk(mclk),
    .rst_n(rst_n),
    .wr_en(phase_q == RSTD_WR && hit_q), // R01 R05 R09
    .wr_idx(idx_q),
    .wr_data(hwdata[7:0]),
    .rd_en(take && !hwrite),
    .rd_idx(hit ? idx : {RSTD_IDX_W{1'b1}}),
    .rd_data(rd_byte),
    .reg_ref(reg_ref),
    .reg_pos(reg_pos),
    .reg_neg(reg_neg)
  );

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = {24'h000000, rd_byte}; // R10

  // ********************
  // field outputs
  // ********************
  // reserved select codes pass through unchecked; software keeps clear
  assign ref_select.pos_reference_select =
    reg_ref[RSTD_PSEL_MSB:RSTD_PSEL_LSB]; // R02 R04
  assign ref_select.neg_reference_select =
    reg_ref[RSTD_NSEL_MSB:RSTD_NSEL_LSB]; // R03 R04
  assign pos_test.pin_connect = reg_pos[RSTD_CONN_BIT]; // R06
  assign pos_test.magnitude = reg_pos[RSTD_MAG_MSB:RSTD_MAG_LSB]; // R07 R08
  assign neg_test.pin_connect = reg_neg[RSTD_CONN_BIT];
  assign neg_test.magnitude = reg_neg[RSTD_MAG_MSB:RSTD_MAG_LSB];

  // ********************
  // checks
  // ********************
  logic past_valid_q;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      past_valid_q <= 1'b0;
    end else begin
      past_valid_q <= 1'b1;
    end
  end

  // stored byte rebuilt from the field outputs, reserved bits as zero
  function automatic logic [7:0] ref_byte(input rstd_ref_t r);
    ref_byte = {2'h0, r.pos_reference_select, r.neg_reference_select};
  endfunction : ref_byte

  // both test registers share one layout
  function automatic logic [7:0] test_byte(input rstd_test_t t);
    test_byte = {t.pin_connect, 2'h0, t.magnitude};
  endfunction : test_byte

  // ********************
  // reset values
  // ********************
  a_ref_reset_zero: assert property ( // R01
    @(posedge mclk) !past_valid_q |-> ref_select == '0)
    else $error("reference select not zero after reset");

  a_pos_reset_zero: assert property ( // R05
    @(posedge mclk) !past_valid_q |-> pos_test == '0)
    else $error("positive test control not zero after reset");

  a_neg_reset_zero: assert property ( // R09
    @(posedge mclk) !past_valid_q |-> neg_test == '0)
    else $error("negative test control not zero after reset");

  a_read_reset_zero: assert property ( // R01
    @(posedge mclk) !past_valid_q |-> hrdata == '0)
    else $error("read data not zero after reset");

  // ********************
  // write path
  // ********************
  a_pos_sel_write: assert property ( // R02
    @(posedge mclk) disable iff (!rst_n)
    (phase_q == RSTD_WR && hit_q && idx_q == 2'h0) |=>
    ref_select.pos_reference_select ==
    $past(hwdata[RSTD_PSEL_MSB:RSTD_PSEL_LSB]))
    else $error("positive select did not take written bits");

  a_neg_sel_write: assert property ( // R03
    @(posedge mclk) disable iff (!rst_n)
    (phase_q == RSTD_WR && hit_q && idx_q == 2'h0) |=>
    ref_select.neg_reference_select ==
    $past(hwdata[RSTD_NSEL_MSB:RSTD_NSEL_LSB]))
    else $error("negative select did not take written bits");

  a_pos_conn_write: assert property ( // R06
    @(posedge mclk) disable iff (!rst_n)
    (phase_q == RSTD_WR && hit_q && idx_q == 2'h1) |=>
    pos_test.pin_connect == $past(hwdata[RSTD_CONN_BIT]))
    else $error("pin connect did not follow write");

  a_pos_mag_write: assert property ( // R07
    @(posedge mclk) disable iff (!rst_n)
    (phase_q == RSTD_WR && hit_q && idx_q == 2'h1) |=>
    pos_test.magnitude == $past(hwdata[RSTD_MAG_MSB:RSTD_MAG_LSB]))
    else $error("magnitude did not follow write");

  a_neg_conn_write: assert property ( // R09
    @(posedge mclk) disable iff (!rst_n)
    (phase_q == RSTD_WR && hit_q && idx_q == 2'h2) |=>
    neg_test.pin_connect == $past(hwdata[RSTD_CONN_BIT]))
    else $error("negative pin connect did not follow write");

  a_neg_mag_write: assert property ( // R09
    @(posedge mclk) disable iff (!rst_n)
    (phase_q == RSTD_WR && hit_q && idx_q == 2'h2) |=>
    neg_test.magnitude == $past(hwdata[RSTD_MAG_MSB:RSTD_MAG_LSB]))
    else $error("negative magnitude did not follow write");

  // ********************
  // field outputs hold between writes
  // ********************
  a_sel_stable: assert property ( // R02
    @(posedge mclk) disable iff (!rst_n)
    !(phase_q == RSTD_WR && hit_q && idx_q == 2'h0) |=> $stable(ref_select))
    else $error("reference select changed without a write");

  a_pos_stable: assert property ( // R06
    @(posedge mclk) disable iff (!rst_n)
    !(phase_q == RSTD_WR && hit_q && idx_q == 2'h1) |=> $stable(pos_test))
    else $error("positive test control changed without a write");

  a_neg_stable: assert property ( // R09
    @(posedge mclk) disable iff (!rst_n)
    !(phase_q == RSTD_WR && hit_q && idx_q == 2'h2) |=> $stable(neg_test))
    else $error("negative test control changed without a write");

  // ********************
  // read path
  // ********************
  a_rsvd_read_zero: assert property ( // R10
    @(posedge mclk) disable iff (!rst_n)
    (take && !hwrite && hit && idx == 2'h0) |=>
    hrdata[7:6] == 2'h0 && hrdata[31:8] == 24'h0)
    else $error("reserved reference bits read nonzero");

  a_rsvd_test_zero: assert property ( // R10
    @(posedge mclk) disable iff (!rst_n)
    (take && !hwrite && hit && idx != 2'h0) |=>
    hrdata[6:5] == 2'h0)
    else $error("reserved test bits read nonzero");

  a_ref_read_data: assert property ( // R01
    @(posedge mclk) disable iff (!rst_n)
    (take && !hwrite && hit && idx == 2'h0) |=>
    hrdata[7:0] == ref_byte(ref_select))
    else $error("reference read data differs from register");

  a_pos_read_data: assert property ( // R05
    @(posedge mclk) disable iff (!rst_n)
    (take && !hwrite && hit && idx == 2'h1) |=>
    hrdata[7:0] == test_byte(pos_test))
    else $error("positive test read data differs from register");

  a_neg_read_data: assert property ( // R09
    @(posedge mclk) disable iff (!rst_n)
    (take && !hwrite && hit && idx == 2'h2) |=>
    hrdata[7:0] == test_byte(neg_test))
    else $error("negative test read data differs from register");

  a_miss_read_zero: assert property ( // R01
    @(posedge mclk) disable iff (!rst_n)
    (take && !hwrite && !hit) |=>
    hrdata == '0)
    else $error("unmapped read returned nonzero data");

  a_read_hold: assert property ( // R10
    @(posedge mclk) disable iff (!rst_n)
    !(take && !hwrite) |=>
    $stable(hrdata))
    else $error("read data changed without a read");

  // ********************
  // address decode
  // ********************
  a_ref_decode: assert property ( // R01
    @(posedge mclk) disable iff (!rst_n)
    (hsize == RSTD_HSIZE_WORD && haddr == {RSTD_REF_INDEX[29:0], 2'h0}) |->
    hit && idx == 2'h0)
    else $error("reference register address not decoded");

  a_pos_decode: assert property ( // R05
    @(posedge mclk) disable iff (!rst_n)
    (hsize == RSTD_HSIZE_WORD && haddr == {RSTD_POS_INDEX[29:0], 2'h0}) |->
    hit && idx == 2'h1)
    else $error("positive test register address not decoded");

  a_neg_decode: assert property ( // R09
    @(posedge mclk) disable iff (!rst_n)
    (hsize == RSTD_HSIZE_WORD && haddr == {RSTD_NEG_INDEX[29:0], 2'h0}) |->
    hit && idx == 2'h2)
    else $error("negative test register address not decoded");

  a_narrow_miss: assert property ( // R01
    @(posedge mclk) disable iff (!rst_n)
    (hsize != RSTD_HSIZE_WORD) |->
    !hit)
    else $error("narrow access decoded as a register");

  a_misaligned_miss: assert property ( // R01
    @(posedge mclk) disable iff (!rst_n)
    (haddr[1:0] != 2'h0) |->
    !hit)
    else $error("misaligned access decoded as a register");

  // ********************
  // scenarios
  // ********************
  c_ref_write: cover property (@(posedge mclk) disable iff (!rst_n)
    phase_q == RSTD_WR && hit_q && idx_q == 2'h0);
  c_pos_connect: cover property (@(posedge mclk) disable iff (!rst_n)
    pos_test.pin_connect);
  c_supply_ref: cover property (@(posedge mclk) disable iff (!rst_n)
    ref_select.pos_reference_select == RSTD_SEL_SUPPLY);
  c_read: cover property (@(posedge mclk) disable iff (!rst_n)
    phase_q == RSTD_RD && hit_q);

endmodule : rstd_top

// File: tb/rstd_top_tb.sv
// testbench: register bank checked against a behavioural register model
`timescale 1ns/1ps
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin n_fail++; \
  $display("BAD %0t got %h exp %h", $time, (a), (e)); end end
module rstd_top_tb;
  import rstd_pkg::*;
  // ********************
  // signals and model
  // ********************
  logic mclk;
  logic rst_n;
  logic hsel;
  logic hwrite;
  logic [31:0] haddr;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic hreadyout;
  logic hresp;
  rstd_ref_t ref_select;
  rstd_test_t pos_test;
  rstd_test_t neg_test;
  logic [7:0] m [3];
  logic [4:0] mags [5] = '{5'h00, 5'h01, 5'h09, 5'h11, 5'h18};
  int n_fail = 0;
  int n_compared = 0;
  int k;

  rstd_top i_dut (.mclk(mclk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .ref_select(ref_select), .pos_test(pos_test),
    .neg_test(neg_test));

  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  // ********************
  // bus tasks
  // ********************
  task automatic xfer(input logic [31:0] a, input logic w,
                      input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= RSTD_HTRANS_NONSEQ;
    @(posedge mclk);
    while (hreadyout !== 1'b1) @(posedge mclk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge mclk);
    while (hreadyout !== 1'b1) @(posedge mclk);
    rd = hrdata;
    `CHK(hresp, 1'b0)
  endtask : xfer

  function automatic logic [31:0] addr(input int i);
    return (RSTD_REF_INDEX + i) * 4;
  endfunction : addr

  // reserved bits are never stored, so the model drops them too
  task automatic wr(input int i, input logic [31:0] d);
    xfer(addr(i), 1'b1, d);
    m[i] = d[7:0] & ((i == 0) ? 8'h3f : 8'h9f);
  endtask : wr

  // random legal byte: defined codes only, reserved bits clear
  function automatic logic [7:0] legal_byte(input int i);
    logic [4:0] mag;
    int r;
    r = $urandom_range(17, 0);
    mag = (r < 10) ? 5'(r) : 5'(r + 7);
    if (i == 0)
      return {2'h0, 3'($urandom_range(4, 0)), 3'($urandom_range(4, 0))};
    return {1'($urandom_range(1, 0)), 2'h0, mag};
  endfunction : legal_byte

  task automatic check_all;
    #1;
    `CHK(ref_select, m[0][5:0])
    `CHK(pos_test, {m[1][7], m[1][4:0]})
    `CHK(neg_test, {m[2][7], m[2][4:0]})
    @(posedge mclk);
    for (int i = 0; i < 3; i++) begin
      xfer(addr(i), 1'b0, 32'h0);
      `CHK(rd, {24'h0, m[i]})
    end
  endtask : check_all

  task automatic end_of_test;
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : end_of_test

  initial begin
    repeat (5000) @(posedge mclk);
    n_fail++;
    end_of_test;
  end

  initial begin
    rst_n = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = RSTD_HSIZE_WORD;
    hwdata = 32'h0;
    m = '{default: 8'h00};
    void'($urandom(32'haf843d17));
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    check_all;
    $display("test reset done");
    // every defined select code and a spread of magnitude codes
    for (int c = 0; c < 5; c++) begin
      wr(0, {26'h0, c[2:0], 3'(4 - c)});
      wr(1, {24'h0, c[0], 2'h0, mags[c]});
      wr(2, {24'h0, ~c[0], 2'h0, mags[4 - c]});
      check_all;
    end
    $display("test codes done");
    // random legal bytes under random upper bus bits, read straight back
    repeat (16) begin
      k = $urandom_range(2, 0);
      wr(k, {24'($urandom), legal_byte(k)});
      xfer(addr(k), 1'b0, 32'h0);
      `CHK(rd, {24'h0, m[k]})
      check_all;
    end
    $display("test random done");
    // unmapped, misaligned and narrow accesses must change nothing
    xfer(32'h48, 1'b1, $urandom);
    xfer(32'h3d, 1'b1, $urandom);
    hsize <= 3'h0;
    xfer(addr(1), 1'b1, 32'h9f);
    hsize <= RSTD_HSIZE_WORD;
    xfer(32'h48, 1'b0, 32'h0);
    `CHK(rd, 32'h0)
    check_all;
    $display("test unmapped done");
    end_of_test;
  end
endmodule : rstd_top_tb
